// >>> shared/iwc_pkg.sv
// Constants shared by both ends of the wait and address-match link
`default_nettype none

package iwc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ   = 10_000_000;
  localparam int CLK_KHZ  = CLK_HZ / 1000;
  localparam int HALF_NS  = 5000;
  localparam int HALF_CYC = (HALF_NS * CLK_KHZ + 999_999) / 1_000_000;
  localparam int TMR_W    = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTL0  = 8'h00;
  localparam logic [7:0] A_CTL1  = 8'h04;
  localparam logic [7:0] A_STAT  = 8'h08;
  localparam logic [7:0] A_SHIFT = 8'h0c;
  localparam logic [7:0] A_SVA   = 8'h10;
  localparam logic [7:0] A_XINFO = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C0_STOP  = 0;
  localparam int C0_START = 1;
  localparam int C0_ACK_ENABLE  = 2;
  localparam int C0_WAIT_TIMING_SELECT  = 3;
  localparam int C0_STOP_INTERRUPT_ENABLE  = 4;
  localparam int C0_WAIT_RELEASE  = 5;
  localparam int C0_BUS_WITHDRAW  = 6;
  localparam int C0_INTERFACE_OPERATION_ENABLE  = 7;
  localparam int C1_WUP   = 7;

  // ----------------------------------------------------------------
  // Bit counts and codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CLK_ZERO = 4'h0;
  localparam logic [3:0] CLK_ONE  = 4'h1;
  localparam logic [3:0] CLK_8    = 4'h8;
  localparam logic [3:0] CLK_9    = 4'h9;
  localparam logic [3:0] EXT_LO   = 4'h0;
  localparam logic [3:0] EXT_HI   = 4'hf;
  localparam logic [7:0] BYTE_FF  = 8'hff;
  localparam logic [6:0] GEN_CALL = 7'h00;

  typedef enum logic [2:0] {
    S_IDLE, S_RUN, S_RS0, S_ST1, S_ST2, S_SP0, S_SP1
  } iwc_seq_e;

endpackage

`default_nettype wire

// >>> shared/iwc_if.sv
// Two-wire bus joining the controller and its bus partner
`default_nettype none

interface iwc_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic ptn_scl_o;
  logic ptn_scl_oe;
  logic ptn_sda_o;
  logic ptn_sda_oe;
  logic serial_clock_pin;
  logic serial_data_pin;

  // Open drain with pull-up: low while any enabled driver drives low
  assign serial_clock_pin = !((dev_scl_oe && !dev_scl_o) ||
                              (ptn_scl_oe && !ptn_scl_o));
  assign serial_data_pin  = !((dev_sda_oe && !dev_sda_o) ||
                              (ptn_sda_oe && !ptn_sda_o));

  modport dev (
    input  serial_clock_pin, serial_data_pin,
    output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe
  );
  modport ptn (
    input  serial_clock_pin, serial_data_pin,
    output ptn_scl_o, ptn_scl_oe, ptn_sda_o, ptn_sda_oe
  );
endinterface

`default_nettype wire

// >>> rtl/iwc_ctrl.sv
// Bus controller: wait control, interrupt timing, address match
// How it works
// - Waiting device holds clock low
// - Receive: release/FF write; transmit: write
// - Shift write releases wait, sends byte
// - Wait-release bit ends the wait
// - Master start request releases, repeats start
// - Master stop request releases, sends stop
// - Software: one release action per wait
// - Disable stops communication, drops wait
// - Bus withdraw leaves transfer, drops wait
// - Wakeup enable blocks every release action
// - Data wait on clock 8 or 9
// - Master address wait on clock 9
// - Own address: forced ack, wait clock 9
// - Foreign address: no interrupt, no wait
// - Miss after restart: interrupt, no wait
// - Stop interrupt only when enabled
// - Software decides ack before 8-clock release
// - Shift register captures data line
// - Extension code flag, interrupt clock 8
// - Ten-bit nibble sets extension, full coincidence
// - Extension code joins; withdraw returns standby
// - Decode general call, ten-bit write/read
`default_nettype none

module iwc_ctrl (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Event
  output logic             bus_interrupt,
  // Bus
  iwc_if.dev               bus
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic       ack_enable, wait_timing_select, stop_interrupt_enable;
  logic       interface_operation_enable, wakeup_enable;
  logic [7:0] own_slave_address_reg, shift_register;
  logic       wr_ph;
  logic [7:0] ph_addr;
  logic       scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic [3:0] bitcnt;
  logic       addr_ph, trc, ack_force, was_sel, ackd;
  logic       address_coincidence_flag, extension_code_flag;
  logic       start_seen, stop_seen, wait_hold, master, mscl_low;
  logic [2:0] ext_kind;
  logic [iwc_pkg::TMR_W-1:0] tmr;
  iwc_pkg::iwc_seq_e seq;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  wire       take    = hsel & htrans[1] & hready;
  wire [7:0] wd      = hwdata[7:0];
  wire       w_ctl0  = wr_ph & (ph_addr == iwc_pkg::A_CTL0);
  wire       w_ctl1  = wr_ph & (ph_addr == iwc_pkg::A_CTL1);
  wire       w_shift = wr_ph & (ph_addr == iwc_pkg::A_SHIFT);
  wire       w_sva   = wr_ph & (ph_addr == iwc_pkg::A_SVA);
  wire       req_rel = w_ctl0 & wd[iwc_pkg::C0_WAIT_RELEASE];
  wire       req_stt = w_ctl0 & wd[iwc_pkg::C0_START];
  wire       req_spt = w_ctl0 & wd[iwc_pkg::C0_STOP];
  wire [7:0] stat = {master, wait_hold, extension_code_flag,
                     address_coincidence_flag, trc, ackd,
                     start_seen, stop_seen};
  wire [7:0] ctl0_rd = {interface_operation_enable, 2'b00,
                        stop_interrupt_enable, wait_timing_select,
                        ack_enable, 2'b00};
  wire [7:0] a       = haddr[7:0];
  wire [7:0] rd_byte =
    (a == iwc_pkg::A_CTL0)  ? ctl0_rd :
    (a == iwc_pkg::A_CTL1)  ? {wakeup_enable, 7'h00} :
    (a == iwc_pkg::A_STAT)  ? stat :
    (a == iwc_pkg::A_SHIFT) ? shift_register :
    (a == iwc_pkg::A_SVA)   ? own_slave_address_reg :
    (a == iwc_pkg::A_XINFO) ? {5'h00, ext_kind} : 8'h00;

  // ----------------------------------------------------------------
  // Line events
  // ----------------------------------------------------------------
  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;
  wire fall8     = scl_fall & (bitcnt == iwc_pkg::CLK_8);
  wire fall9     = scl_fall & (bitcnt == iwc_pkg::CLK_9);
  wire selected  = address_coincidence_flag | extension_code_flag;
  wire active    = master | selected;
  wire addr_match = shift_register[7:1] == own_slave_address_reg[7:1];
  wire ext_code  = (shift_register[7:4] == iwc_pkg::EXT_LO) |
                   (shift_register[7:4] == iwc_pkg::EXT_HI);
  wire slv_addr8 = fall8 & addr_ph & ~master;
  wire slv_addr9 = fall9 & addr_ph & ~master;

  wire ev_ext    = slv_addr8 & ext_code;
  wire ev_match  = slv_addr9 & address_coincidence_flag &
                   ~extension_code_flag;
  wire ev_rsmiss = slv_addr9 & ~selected & was_sel;
  wire ev_maddr  = fall9 & addr_ph & master;
  wire ev_data   = ~addr_ph & active &
                   (wait_timing_select ? fall9 : fall8);
  wire ev_wait   = ev_ext | ev_match | ev_maddr | ev_data;
  wire ev_int    = ev_wait | ev_rsmiss |
                   (stop_det & stop_interrupt_enable);

  // Any release is void while wakeup is enabled; start and stop
  // count only for a master
  wire rel_any = ~wakeup_enable &
                 (w_shift | req_rel |
                  (master & (req_stt | req_spt)));
  wire abort   = ~interface_operation_enable |
                 (w_ctl0 & wd[iwc_pkg::C0_BUS_WITHDRAW]);

  // ----------------------------------------------------------------
  // Data line drive
  // ----------------------------------------------------------------
  wire [3:0] clk_next = (bitcnt == iwc_pkg::CLK_9) ? iwc_pkg::CLK_ONE :
                        4'(bitcnt + iwc_pkg::CLK_ONE);
  wire tx_bit  = trc & (addr_ph ? master : active) & ~shift_register[7];
  // Ack is read live so an ack-enable write made during an 8-clock
  // wait still takes effect
  wire ack_bit = addr_ph ? ack_force : (active & ~trc & ack_enable);
  wire eng_sda = (clk_next == iwc_pkg::CLK_9) ? ack_bit : tx_bit;
  wire seq_ovr = (seq != iwc_pkg::S_IDLE) & (seq != iwc_pkg::S_RUN);
  wire seq_sda = (seq == iwc_pkg::S_ST2) | (seq == iwc_pkg::S_SP0) |
                 (seq == iwc_pkg::S_SP1);
  // Data may only move while the clock is low; a bystander lets go
  // at once, so the line rises at the end of a stop sequence
  wire next_sda = abort ? 1'b0 : seq_ovr ? seq_sda :
                  ((~scl_s | ~active) ? eng_sda : bus.dev_sda_oe);
  wire next_scl = ~abort & (wait_hold | mscl_low);
  wire seq_half = tmr == iwc_pkg::TMR_W'(iwc_pkg::HALF_CYC - 1);
  wire go_start = req_stt & ~start_seen & ~selected &
                  interface_operation_enable;
  wire go_rs    = rel_any & master & req_stt & wait_hold;
  wire go_sp    = rel_any & master & req_spt & wait_hold;

  assign bus.dev_scl_o = 1'b0;
  assign bus.dev_sda_o = 1'b0;

  // ----------------------------------------------------------------
  // Bus slave and software registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph <= 1'b0;
      ph_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (hready)
    begin
      wr_ph <= take & hwrite;
      ph_addr <= a;
      hrdata <= {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {ack_enable, wait_timing_select, stop_interrupt_enable} <= 3'b000;
      interface_operation_enable <= 1'b0;
      wakeup_enable <= 1'b0;
      own_slave_address_reg <= 8'h00;
    end
    else
    begin
      if (w_ctl0)
      begin
        ack_enable <= wd[iwc_pkg::C0_ACK_ENABLE];
        wait_timing_select <= wd[iwc_pkg::C0_WAIT_TIMING_SELECT];
        stop_interrupt_enable <= wd[iwc_pkg::C0_STOP_INTERRUPT_ENABLE];
        interface_operation_enable <= wd[iwc_pkg::C0_INTERFACE_OPERATION_ENABLE];
      end
      if (w_ctl1)
        wakeup_enable <= wd[iwc_pkg::C1_WUP];
      if (w_sva)
        own_slave_address_reg <= wd;
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers, bit counter, shift register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3f;
      bitcnt <= iwc_pkg::CLK_ZERO;
      shift_register <= 8'h00;
      ackd <= 1'b0;
    end
    else
    begin
      {scl_m, scl_s, scl_d} <= {bus.serial_clock_pin, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {bus.serial_data_pin, sda_m, sda_s};
      if (start_det)
        bitcnt <= iwc_pkg::CLK_ZERO;
      else if (scl_rise)
        bitcnt <= clk_next;
      if (w_shift)
        shift_register <= wd;
      // Ack clock kept out so a byte survives a nine-clock wait
      else if (scl_rise & (addr_ph | active) &
               (clk_next != iwc_pkg::CLK_9))
        shift_register <= {shift_register[6:0], sda_s};
      if (scl_rise & (bitcnt == iwc_pkg::CLK_8))
        ackd <= ~sda_s;
    end
  end

  // ----------------------------------------------------------------
  // Address handling and wait
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {addr_ph, trc, ack_force, was_sel} <= 4'h0;
      {address_coincidence_flag, extension_code_flag} <= 2'b00;
      {start_seen, stop_seen, wait_hold} <= 3'b000;
      ext_kind <= 3'b000;
      bus_interrupt <= 1'b0;
    end
    else
    begin
      bus_interrupt <= ev_int & ~abort;
      if (abort)
      begin
        {addr_ph, was_sel, start_seen} <= 3'b000;
        {address_coincidence_flag, extension_code_flag} <= 2'b00;
        wait_hold <= 1'b0;
      end
      else
      begin
        if (start_det)
        begin
          addr_ph <= 1'b1;
          trc <= master;
          ack_force <= 1'b0;
          {start_seen, stop_seen} <= 2'b10;
          {address_coincidence_flag, extension_code_flag} <= 2'b00;
        end
        else if (stop_det)
        begin
          {start_seen, stop_seen, was_sel} <= 3'b010;
          {address_coincidence_flag, extension_code_flag} <= 2'b00;
        end
        if (fall9 & addr_ph)
        begin
          addr_ph <= 1'b0;
          was_sel <= master | selected;
        end
        if (fall8 & addr_ph)
          trc <= master ? ~shift_register[0] : shift_register[0];
        if (slv_addr8)
        begin
          // Own address register is left untouched here
          address_coincidence_flag <= addr_match;
          extension_code_flag <= ext_code;
          ack_force <= addr_match | (ext_code & ack_enable);
          ext_kind <= {ext_code & shift_register[0],
                       ext_code & ~shift_register[0] &
                       (shift_register[7:4] == iwc_pkg::EXT_HI),
                       (shift_register[7:1] == iwc_pkg::GEN_CALL) &
                       ~shift_register[0]};
        end
        // A wait event wins over a release in the same cycle
        if (ev_wait | ((seq == iwc_pkg::S_ST2) & seq_half))
          wait_hold <= 1'b1;
        else if (rel_any)
          wait_hold <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Master clock and condition sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      seq <= iwc_pkg::S_IDLE;
      tmr <= '0;
      mscl_low <= 1'b0;
      master <= 1'b0;
      bus.dev_scl_oe <= 1'b0;
      bus.dev_sda_oe <= 1'b0;
    end
    else
    begin
      bus.dev_scl_oe <= next_scl;
      bus.dev_sda_oe <= next_sda;
      if (abort)
      begin
        seq <= iwc_pkg::S_IDLE;
        tmr <= '0;
        mscl_low <= 1'b0;
        master <= 1'b0;
      end
      else
      begin
        // Each timed phase restarts its half-period count
        tmr <= seq_half ? '0 : tmr + 1'b1;
        case (seq)
          iwc_pkg::S_IDLE:
          begin
            tmr <= '0;
            if (go_start)
            begin
              seq <= iwc_pkg::S_ST2;
              master <= 1'b1;
            end
          end
          iwc_pkg::S_RUN:
          begin
            tmr <= '0;
            if (go_sp)
              seq <= iwc_pkg::S_SP0;
            else if (go_rs)
              seq <= iwc_pkg::S_RS0;
            else if (wait_hold)
              mscl_low <= 1'b1;
            else if (mscl_low | scl_s)
            begin
              // High time counts only once the line is seen high,
              // so a stretching slave holds the master back
              tmr <= seq_half ? '0 : tmr + 1'b1;
              if (seq_half)
                mscl_low <= ~mscl_low;
            end
          end
          iwc_pkg::S_RS0, iwc_pkg::S_SP0:
            if (seq_half)
            begin
              mscl_low <= 1'b0;
              seq <= (seq == iwc_pkg::S_RS0) ? iwc_pkg::S_ST1 :
                                               iwc_pkg::S_SP1;
            end
          iwc_pkg::S_ST1, iwc_pkg::S_SP1:
            if (!scl_s)
              tmr <= '0;
            else if (seq_half)
            begin
              seq <= (seq == iwc_pkg::S_ST1) ? iwc_pkg::S_ST2 :
                                               iwc_pkg::S_IDLE;
              master <= (seq == iwc_pkg::S_ST1);
            end
          iwc_pkg::S_ST2:
            if (seq_half)
            begin
              mscl_low <= 1'b1;
              seq <= iwc_pkg::S_RUN;
            end
          default:
            seq <= iwc_pkg::S_IDLE;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// >>> rtl/iwc_partner.sv
// Far end: a simple bus slave that can stretch the clock
`default_nettype none

module iwc_partner (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Bus
  iwc_if.ptn              bus,
  // User side
  input  wire logic [6:0] own_addr,
  input  wire logic [7:0] tx_byte,
  input  wire logic       hold_clock,
  output logic [7:0]      rx_byte,
  output logic            rx_valid,
  output logic            selected
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic       scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic [3:0] bitcnt;
  logic       addr_ph, rw;
  logic [7:0] rxsh, txsh;

  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;
  wire fall8     = scl_fall & (bitcnt == iwc_pkg::CLK_8);
  wire fall9     = scl_fall & (bitcnt == iwc_pkg::CLK_9);
  wire [3:0] clk_next = (bitcnt == iwc_pkg::CLK_9) ? iwc_pkg::CLK_ONE :
                        4'(bitcnt + iwc_pkg::CLK_ONE);
  wire ack_bit = addr_ph ? (rxsh[7:1] == own_addr) : (selected & ~rw);
  wire tx_bit  = selected & rw & ~addr_ph & ~txsh[7];
  wire eng_sda = (clk_next == iwc_pkg::CLK_9) ? ack_bit : tx_bit;
  wire next_sda = ~scl_s ? eng_sda : bus.ptn_sda_oe;
  // Stretch only once the clock is already low
  wire next_scl = hold_clock & (bus.ptn_scl_oe | ~scl_s);

  assign bus.ptn_scl_o = 1'b0;
  assign bus.ptn_sda_o = 1'b0;

  // ----------------------------------------------------------------
  // Receive, transmit and drive
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3f;
      bitcnt <= iwc_pkg::CLK_ZERO;
      {addr_ph, rw, selected, rx_valid} <= 4'h0;
      rxsh <= 8'h00;
      txsh <= 8'h00;
      rx_byte <= 8'h00;
      bus.ptn_scl_oe <= 1'b0;
      bus.ptn_sda_oe <= 1'b0;
    end
    else
    begin
      {scl_m, scl_s, scl_d} <= {bus.serial_clock_pin, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {bus.serial_data_pin, sda_m, sda_s};
      bus.ptn_scl_oe <= next_scl;
      bus.ptn_sda_oe <= next_sda;
      rx_valid <= fall8 & ~addr_ph & selected & ~rw;
      if (fall8 & ~addr_ph & selected & ~rw)
        rx_byte <= rxsh;
      if (start_det)
      begin
        bitcnt <= iwc_pkg::CLK_ZERO;
        addr_ph <= 1'b1;
        selected <= 1'b0;
      end
      else if (stop_det)
      begin
        addr_ph <= 1'b0;
        selected <= 1'b0;
      end
      else if (scl_rise)
      begin
        bitcnt <= clk_next;
        rxsh <= {rxsh[6:0], sda_s};
        if (bitcnt == iwc_pkg::CLK_8 && rw && !addr_ph && sda_s)
          selected <= 1'b0;
        if (bitcnt != iwc_pkg::CLK_8)
          txsh <= {txsh[6:0], 1'b1};
      end
      if (fall8 & addr_ph)
      begin
        selected <= rxsh[7:1] == own_addr;
        rw <= rxsh[0];
      end
      if (fall9)
      begin
        addr_ph <= 1'b0;
        txsh <= tx_byte;
      end
    end
  end

endmodule

`default_nettype wire

// >>> sim/iwc_link_props.sv
// Concurrent checks on the two-wire link between both ends
`default_nettype none

module iwc_link_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic ptn_scl_o,
  input wire logic ptn_scl_oe,
  input wire logic ptn_sda_o,
  input wire logic ptn_sda_oe,
  // Event
  input wire logic bus_interrupt
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // Sequences and properties
  // ----------------------------------------------------------------
  sequence s_held;
    dev_scl_oe ##1 dev_scl_oe;
  endsequence
  sequence s_stop;
    serial_clock_pin && $rose(serial_data_pin);
  endsequence
  property p_int_wait;
    bus_interrupt |-> s_held;
  endproperty
  property p_int_once;
    bus_interrupt |=> !bus_interrupt [*8];
  endproperty
  property p_int_low;
    bus_interrupt |-> !serial_clock_pin [*4];
  endproperty
  // Stop interrupt disabled throughout the run
  property p_stop_quiet;
    s_stop |-> !bus_interrupt [*6];
  endproperty
  property p_high_min;
    $rose(serial_clock_pin) |-> serial_clock_pin [*8];
  endproperty
  property p_ptn_ack;
    $rose(ptn_sda_oe) |-> !serial_clock_pin;
  endproperty
  property p_dev_tied;
    !dev_scl_o && !dev_sda_o;
  endproperty
  property p_ptn_tied;
    !ptn_scl_o && !ptn_sda_o;
  endproperty

  a_int_wait: assert property (p_int_wait)
    else $error("interrupt without held clock");
  a_int_once: assert property (p_int_once)
    else $error("interrupt pulses too close");
  a_int_low: assert property (p_int_low)
    else $error("clock not held low in wait");
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("stop interrupt while disabled");
  a_high_min: assert property (p_high_min)
    else $error("clock high phase too short");
  a_ptn_ack: assert property (p_ptn_ack)
    else $error("partner data moved with clock high");
  a_dev_tied: assert property (p_dev_tied)
    else $error("controller drives a high level");
  a_ptn_tied: assert property (p_ptn_tied)
    else $error("partner drives a high level");
endmodule

`default_nettype wire

// >>> sim/iwc_ctrl_tb.sv
// Self-checking bench: controller as master against the partner
`default_nettype none

module iwc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hwrite, hreadyout, hresp, bus_interrupt;
  logic        rx_valid, selected, scl_q, hold;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [7:0]  rx_byte;
  int          err_total, total_checks, falls;

  iwc_if iwc_if_i ();
  iwc_ctrl iwc_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .bus_interrupt(bus_interrupt),
    .bus(iwc_if_i.dev));
  iwc_partner iwc_partner_i (.hclk(hclk), .hresetn(hresetn),
    .bus(iwc_if_i.ptn), .own_addr(7'h2a), .tx_byte(8'h96),
    .hold_clock(hold), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .selected(selected));
  iwc_link_props iwc_link_props_i (.hclk(hclk), .hresetn(hresetn),
    .serial_clock_pin(iwc_if_i.serial_clock_pin),
    .serial_data_pin(iwc_if_i.serial_data_pin),
    .dev_scl_o(iwc_if_i.dev_scl_o), .dev_scl_oe(iwc_if_i.dev_scl_oe),
    .dev_sda_o(iwc_if_i.dev_sda_o), .dev_sda_oe(iwc_if_i.dev_sda_oe),
    .ptn_scl_o(iwc_if_i.ptn_scl_o), .ptn_scl_oe(iwc_if_i.ptn_scl_oe),
    .ptn_sda_o(iwc_if_i.ptn_sda_o), .ptn_sda_oe(iwc_if_i.ptn_sda_oe),
    .bus_interrupt(bus_interrupt));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  always @(posedge hclk)
  begin
    scl_q <= iwc_if_i.serial_clock_pin;
    if (scl_q === 1'b1 && iwc_if_i.serial_clock_pin === 1'b0)
      falls <= falls + 1;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask

  // One single AHB transfer; read data lands in rv
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
    chk(hresp, 0);
  endtask

  task automatic wlow();
    repeat (500)
    begin
      @(posedge hclk);
      if (iwc_if_i.serial_clock_pin === 1'b0) break;
    end
  endtask

  // Checks the number of clock falls up to the interrupt
  task automatic wint(input int n);
    int f0;
    f0 = falls;
    repeat (3000)
    begin
      @(posedge hclk);
      if (bus_interrupt === 1'b1) break;
    end
    chk(bus_interrupt, 1);
    chk(falls - f0, n);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    xfer(0, iwc_pkg::A_CTL0, 8'h00);
    chk(rv, 0);
    xfer(0, 8'h20, 8'h00);
    chk(rv, 0);
    xfer(1, iwc_pkg::A_STAT, 8'hff);
    xfer(0, iwc_pkg::A_STAT, 8'h00);
    chk(rv, 0);
  endtask

  task automatic t_master();
    xfer(1, iwc_pkg::A_CTL0, 8'h80);
    xfer(1, iwc_pkg::A_CTL0, 8'h82);
    wlow();
    xfer(1, iwc_pkg::A_SHIFT, 8'h54);
    wint(9);
    xfer(0, iwc_pkg::A_STAT, 8'h00);
    chk(rv & 32'hcc, 32'hcc);
    chk(selected, 1);
    xfer(1, iwc_pkg::A_SHIFT, 8'h5a);
    wint(8);
    chk(rx_byte, 8'h5a);
    xfer(0, iwc_pkg::A_SHIFT, 8'h00);
    chk(rv, 32'h5a);
    xfer(1, iwc_pkg::A_CTL0, 8'h88);
    xfer(1, iwc_pkg::A_SHIFT, 8'hc3);
    // Pending acknowledge clock runs into the nine-clock wait
    wint(1);
    hold <= 1'b1;
    xfer(1, iwc_pkg::A_CTL0, 8'ha8);
    repeat (200) @(posedge hclk);
    chk(iwc_if_i.serial_clock_pin, 0);
    hold <= 1'b0;
    wint(9);
    chk(rx_byte, 8'hc3);
    xfer(1, iwc_pkg::A_CTL1, 8'h80);
    xfer(1, iwc_pkg::A_CTL0, 8'h89);
    repeat (300) @(posedge hclk);
    chk(iwc_if_i.serial_clock_pin, 0);
    xfer(1, iwc_pkg::A_CTL1, 8'h00);
    xfer(1, iwc_pkg::A_CTL0, 8'h89);
    repeat (400) @(posedge hclk);
    chk(iwc_if_i.serial_clock_pin, 1);
    chk(iwc_if_i.serial_data_pin, 1);
    xfer(0, iwc_pkg::A_STAT, 8'h00);
    chk(rv[0], 1);
  endtask

  task automatic t_disable();
    xfer(1, iwc_pkg::A_CTL0, 8'h82);
    wlow();
    xfer(1, iwc_pkg::A_SHIFT, 8'h22);
    wint(9);
    xfer(0, iwc_pkg::A_STAT, 8'h00);
    chk(rv[2], 0);
    chk(selected, 0);
    xfer(1, iwc_pkg::A_CTL0, 8'h82);
    repeat (300) @(posedge hclk);
    xfer(0, iwc_pkg::A_STAT, 8'h00);
    chk(rv & 32'hc2, 32'hc2);
    xfer(1, iwc_pkg::A_CTL0, 8'h00);
    repeat (200) @(posedge hclk);
    chk(iwc_if_i.serial_clock_pin, 1);
  endtask

  task automatic t_withdraw();
    xfer(1, iwc_pkg::A_CTL0, 8'h80);
    xfer(1, iwc_pkg::A_CTL0, 8'h82);
    wlow();
    xfer(1, iwc_pkg::A_CTL0, 8'hc0);
    repeat (200) @(posedge hclk);
    chk(iwc_if_i.serial_clock_pin, 1);
    chk(iwc_if_i.serial_data_pin, 1);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  initial
  begin
    hresetn = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    hold = 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_master();
    t_disable();
    t_withdraw();
    wrap_up();
  end

  // Limit of about forty bytes of traffic at 1000 cycles each
  initial
  begin
    repeat (40000) @(posedge hclk);
    err_total++;
    wrap_up();
  end
endmodule

`default_nettype wire
